// ==== rtl/nested_interrupt_acceptance.v ====
// nested interrupt acceptance: accept flag, level flag, urgency bits, hold logic
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "nest_accept_regs.vh"
module nested_interrupt_acceptance (
  input wire clock,
  input wire arst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [`SRC_CNT-1:0] src_event,
  input wire ins_done,
  input wire [2:0] ins_class,
  output reg ack_valid,
  output reg [`SRC_IDX_W-1:0] ack_src,
  output reg trap_ack,
  output reg [7:0] status_word
);
  reg [`SRC_CNT-1:0] req_r;
  reg [`SRC_CNT-1:0] req_nxt;
  reg [`SRC_CNT-1:0] block_r;
  reg [`SRC_CNT-1:0] urg_r;
  reg [7:0] psw_r;
  reg [7:0] psw_nxt;
  reg hold_r;
  reg hold_nxt;
  reg gap_r;
  reg gap_nxt;
  reg ack_nxt;
  reg trap_nxt;
  reg [`SRC_IDX_W-1:0] src_nxt;
  wire [`SRC_CNT-1:0] eligible;
  wire [`SRC_CNT-1:0] hi_cand;
  wire hi_found;
  wire lo_found;
  wire [`SRC_IDX_W-1:0] hi_idx;
  wire [`SRC_IDX_W-1:0] lo_idx;
  wire accept_en;
  wire level;
  wire sel_found;
  wire sel_urg;
  wire [`SRC_IDX_W-1:0] sel_idx;
  wire urg_ok;
  wire ins_is_hold;
  wire boundary;
  wire take;
  wire sw_write;

  assign accept_en = psw_r[`PSW_ACCEPT_BIT];
  assign level = psw_r[`PSW_LEVEL_BIT];
  assign sw_write = wr && (addr == `A_PSW);

  genvar g;
  generate
    for (g = 0; g < `SRC_CNT; g = g + 1) begin : g_elig
      assign eligible[g] = req_r[g] & ~block_r[g];
      // urgency 0 is the high level
      assign hi_cand[g] = eligible[g] & ~urg_r[g];
    end
  endgenerate

  priority_pick u_hi (
    .cand(hi_cand),
    .found(hi_found),
    .idx(hi_idx)
  );

  priority_pick u_lo (
    .cand(eligible),
    .found(lo_found),
    .idx(lo_idx)
  );

  // high urgency group first, fixed order inside
  assign sel_found = hi_found | lo_found;
  assign sel_idx = hi_found ? hi_idx : lo_idx;
  assign sel_urg = ~hi_found;

  // nesting judged by urgency bit against level flag
  // low urgency refused under high service
  // level 0 admits only high urgency
  assign urg_ok = level | ~sel_urg;

  // hold classes cover psw ops, returns, accept/mask, ctl writes
  // trap class is not a hold instruction
  assign ins_is_hold = (ins_class == `INS_HOLD) || (ins_class == `INS_ACCEPT_ALL) ||
                       (ins_class == `INS_MASK_ALL) || (ins_class == `INS_RET_MASKABLE) ||
                       (ins_class == `INS_RET_TRAP);

  // an instruction boundary is the only point where acknowledge may happen
  assign boundary = ins_done && (ins_class != `INS_TRAP);

  // hold and return gap both defer
  // gap after return forces one main instruction
  assign take = boundary && accept_en && sel_found && urg_ok && !ins_is_hold && !hold_r && !gap_r;

  always @* begin
    req_nxt = req_r;
    psw_nxt = psw_r;
    hold_nxt = hold_r;
    gap_nxt = gap_r;
    ack_nxt = 1'b0;
    trap_nxt = 1'b0;
    src_nxt = ack_src;
    // software clear applies first so a same-cycle event wins
    if (wr && (addr == `A_REQ)) begin
      req_nxt = req_r & wdata;
    end
    if (sw_write) begin
      psw_nxt = wdata;
    end
    if (ins_done) begin
      hold_nxt = ins_is_hold;
      // gap lasts until one instruction completes after return
      gap_nxt = (ins_class == `INS_RET_MASKABLE) || (ins_class == `INS_RET_TRAP);
      case (ins_class)
        `INS_ACCEPT_ALL: begin
          psw_nxt[`PSW_ACCEPT_BIT] = 1'b1;
        end
        `INS_MASK_ALL: begin
          psw_nxt[`PSW_ACCEPT_BIT] = 1'b0;
        end
        `INS_TRAP: begin
          trap_nxt = 1'b1;
          psw_nxt[`PSW_ACCEPT_BIT] = 1'b0;
        end
        default: begin
          psw_nxt = psw_nxt;
        end
      endcase
    end
    if (take) begin
      ack_nxt = 1'b1;
      src_nxt = sel_idx;
      req_nxt[sel_idx] = 1'b0;
      psw_nxt[`PSW_ACCEPT_BIT] = 1'b0;
      psw_nxt[`PSW_LEVEL_BIT] = urg_r[sel_idx];
    end
    // request set path ignores urgency bits
    req_nxt = req_nxt | src_event;
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= `ZERO8;
      block_r <= `BLOCK_RST;
      urg_r <= `URG_RST;
      psw_r <= `PSW_RST;
      hold_r <= 1'b0;
      gap_r <= 1'b0;
      ack_valid <= 1'b0;
      ack_src <= {`SRC_IDX_W{1'b0}};
      trap_ack <= 1'b0;
      status_word <= `PSW_RST;
    end else begin
      req_r <= req_nxt;
      psw_r <= psw_nxt;
      status_word <= psw_nxt;
      hold_r <= hold_nxt;
      gap_r <= gap_nxt;
      ack_valid <= ack_nxt;
      ack_src <= src_nxt;
      trap_ack <= trap_nxt;
      if (wr && (addr == `A_BLOCK)) begin
        block_r <= wdata;
      end
      if (wr && (addr == `A_URG)) begin
        urg_r <= wdata;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `ZERO8;
    end else if (rd) begin
      case (addr)
        `A_REQ: begin
          rdata <= req_r;
        end
        `A_BLOCK: begin
          rdata <= block_r;
        end
        `A_URG: begin
          rdata <= urg_r;
        end
        `A_PSW: begin
          rdata <= psw_r;
        end
        `A_STAT: begin
          rdata <= {4'h0, gap_r, hold_r, sel_found, lo_found};
        end
        default: begin
          rdata <= `ZERO8;
        end
      endcase
    end else begin
      rdata <= `ZERO8;
    end
  end
endmodule // nested_interrupt_acceptance

// ==== rtl/nest_accept_regs.vh ====
// constants for the nested interrupt acceptance block
`ifndef NEST_ACCEPT_REGS_VH
`define NEST_ACCEPT_REGS_VH
`define SRC_CNT 8
`define SRC_IDX_W 3
// register index map (4-bit word address)
`define A_REQ 4'h0
`define A_BLOCK 4'h1
`define A_URG 4'h2
`define A_PSW 4'h3
`define A_STAT 4'h4
// status word layout and reset value
`define PSW_RST 8'h02
`define PSW_ACCEPT_BIT 7
`define PSW_LEVEL_BIT 1
`define BLOCK_RST 8'hFF
`define URG_RST 8'hFF
`define ZERO8 8'h00
// instruction class codes from the sequencer
`define INS_PLAIN 3'h0
`define INS_HOLD 3'h1
`define INS_ACCEPT_ALL 3'h2
`define INS_MASK_ALL 3'h3
`define INS_TRAP 3'h4
`define INS_RET_MASKABLE 3'h5
`define INS_RET_TRAP 3'h6
`endif

// ==== rtl/priority_pick.v ====
// fixed-order picker: lowest index among candidate sources
`timescale 1ns/1ps
`include "nest_accept_regs.vh"
module priority_pick (
  input wire [`SRC_CNT-1:0] cand,
  output reg found,
  output reg [`SRC_IDX_W-1:0] idx
);
  integer i;
  always @* begin
    found = 1'b0;
    idx = {`SRC_IDX_W{1'b0}};
    // scan downward so index 0 wins last
    for (i = `SRC_CNT - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        found = 1'b1;
        idx = i[`SRC_IDX_W-1:0];
      end
    end
  end
endmodule // priority_pick

// ==== verif/nest_accept_properties.sv ====
// port checker for the acceptance block
`timescale 1ns/1ps
module nest_checker (
  input wire clock,
  input wire arst_n,
  input wire ins_done,
  input wire [2:0] ins_class,
  input wire ack_valid,
  input wire trap_ack,
  input wire [7:0] status_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire tk = ins_done && ins_class == 3'h4;
  ack_clear_a: assert property (ack_valid |-> !status_word[7]) else $error("ack kept accept");
  ack_pulse_a: assert property (ack_valid |=> !ack_valid) else $error("ack too long");
  trap_clear_a: assert property (trap_ack |-> !status_word[7]) else $error("trap kept accept");
  trap_taken_a: assert property (tk |=> trap_ack) else $error("trap lost");
  trap_only_a: assert property (tk |=> !ack_valid) else $error("ack on trap");
  closed_gate_a: assert property (ins_done && !status_word[7] |=> !ack_valid) else $error("ack while off");
  hold_defer_a: assert property (ins_done && ins_class inside {1, 2, 3, 5, 6} |=> !ack_valid)
    else $error("ack on hold");
  trap_cause_a: assert property (trap_ack |-> $past(tk)) else $error("stray trap");
  cover property (ack_valid && status_word[1]);
  cover property (ack_valid && !status_word[1]);
  cover property (trap_ack);
endmodule // nest_checker
bind nested_interrupt_acceptance nest_checker chk (.clock, .arst_n, .ins_done, .ins_class, .ack_valid, .trap_ack,
  .status_word);

// ==== verif/seq_model.sv ====
// sequencer stand-in that finishes one instruction per request
`timescale 1ns/1ps
module seq_model (
  input wire clock,
  input wire go,
  input wire [2:0] cls,
  output reg ins_done = 1'b0,
  output reg [2:0] ins_class = 3'h0
);
  always @(posedge clock) begin
    ins_done <= go;
    ins_class <= cls;
  end
endmodule // seq_model

// ==== verif/testbench.sv ====
// self-checking bench for the acceptance block
`timescale 1ns/1ps
module testbench;
  logic clock = 0, arst_n = 0, wr = 0, rd = 0, go = 0, rd_d = 0, ins_done, ack_valid, trap_ack;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, src_event = 8'h00, lf = 8'h49, rdata, status_word;
  logic [2:0] cls = 3'h0, ins_class, ack_src;
  logic [9:0] q[$];
  int bad_count = 0, samples_checked = 0;
  nested_interrupt_acceptance uut (.clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .src_event, .ins_done,
    .ins_class, .ack_valid, .ack_src, .trap_ack, .status_word);
  seq_model seq (.clock, .go, .cls, .ins_done, .ins_class);
  initial forever #5 clock = ~clock;
  function automatic logic [7:0] nx(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(logic [9:0] s, logic [9:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR event exp %h seen %h", e, s);
    end
  endtask
  task automatic pop(logic [9:0] s);
    logic [9:0] e;
    e = q.size() ? q.pop_front() : 10'h3FF;
    check(s, e);
  endtask
  task automatic finish_test();
    bad_count += q.size();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) rd_d <= rd;
  always @(posedge clock) begin
    #1;
    if (rd_d) pop({2'h0, rdata});
    if (ack_valid) pop({2'h1, status_word[7], status_word[1], 3'h0, ack_src});
    if (trap_ack) pop({2'h2, status_word[7], 7'h00});
  end
  task automatic wb(logic w, logic [3:0] a, logic [7:0] d);
    if (!w) q.push_back({2'h0, d});
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic ex(logic [2:0] c, logic [7:0] m);
    @(posedge clock);
    go <= 1'b1;
    cls <= c;
    src_event <= m;
    @(posedge clock);
    go <= 1'b0;
    src_event <= 8'h00;
    repeat (2) @(posedge clock);
  endtask
  task automatic ak(logic u, logic [2:0] s, logic [7:0] m);
    q.push_back({2'h1, 1'b0, u, 3'h0, s});
    ex(3'h0, m);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    wb(0, 4'h3, 8'h02);
    wb(0, 4'h2, 8'hFF);
    wb(0, 4'hF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      wb(1, 4'h2, lf);
      wb(1, 4'h1, ~(8'h01 << i));
      wb(1, 4'h3, 8'h82);
      ak(lf[i], 3'(i), lf | (8'h01 << i));
    end
    wb(1, 4'h0, 8'h00);
    wb(1, 4'h1, 8'h00);
    wb(1, 4'h2, 8'hF0);
    wb(1, 4'h3, 8'h02);
    ex(3'h0, 8'h40);
    wb(0, 4'h0, 8'h40);
    ex(3'h2, 8'h00);
    ex(3'h0, 8'h00);
    ak(1'b1, 3'h6, 8'h00);
    wb(1, 4'h3, 8'h80);
    ex(3'h0, 8'h40);
    ak(1'b0, 3'h1, 8'h06);
    wb(1, 4'h3, 8'h82);
    ex(3'h5, 8'h00);
    ex(3'h0, 8'h00);
    ak(1'b0, 3'h2, 8'h00);
    wb(1, 4'h3, 8'h82);
    q.push_back({2'h2, 8'h00});
    ex(3'h4, 8'h00);
    wb(1, 4'h3, 8'h82);
    ex(3'h6, 8'h00);
    ex(3'h1, 8'h00);
    ex(3'h3, 8'h00);
    ex(3'h0, 8'h00);
    ex(3'h0, 8'h00);
    finish_test();
  end
endmodule // testbench
